/* logic/ssl_loader.sv */
// software strap loader with register port
`include "ssl_consts.svh"
// What this block does
// - register bits act as virtual strap inputs
// - done bit fires internal pulse, latches straps
// - internal reset held until done bit set, then through the pulse
// - done bit readable, writable, resets zero
// - bit fourteen crossover enable, latched to its own output, read at 0x19
// - mode bits force or advertise speed, duplex
// - decoded settings latched to control, advertise
module ssl_loader
  import ssl_pkg::*;
#(
  parameter int PULSE_CYC = `SSL_PULSE_CYC
)
(
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input wire logic [`SSL_ADDR_W-1:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [15:0] rdata_o,
  output logic int_rst_o,
  output logic seq_done_o,
  output logic crossover_auto_enable_o,
  output logic negotiation_enable_o,
  output logic [1:0] negotiation_mode_select_o,
  output logic [15:0] basic_mode_control_o,
  output logic [15:0] advertise_ability_o
);
  typedef struct packed {
    ssl_state_t state;
    logic [15:0] strap;
    logic [7:0] cnt;
    logic int_rst;
    logic done;
    logic xover;
    logic negen;
    logic [1:0] mode;
    logic [15:0] bmc;
    logic [15:0] adv;
    logic [15:0] rdata;
  } ssl_regs_t;

  ssl_regs_t s_reg;
  ssl_regs_t s_next;
  logic [15:0] dec_bmc;
  logic [15:0] dec_adv;

  // decode straps currently held in the register, applied only on the pulse
  ssl_decode u_dec (
    .negen_i(s_reg.strap[`SSL_BIT_NEGEN]),
    .mode_i(s_reg.strap[`SSL_BIT_MODE_HI:`SSL_BIT_MODE_LO]),
    .bmc_o(dec_bmc),
    .adv_o(dec_adv)
  );

  function automatic logic [15:0] ssl_read(input logic [4:0] a,
                                           input ssl_regs_t r);
    logic [15:0] v;
    v = 16'h0000;
    case (a)
      `SSL_OFS_STRAP: v = r.strap;
      `SSL_OFS_STATUS: v = {13'h0000, r.int_rst, r.done,
                            r.state == SSL_WAIT_CFG};
      `SSL_OFS_BMC: v = r.bmc;
      `SSL_OFS_ADV: v = r.adv;
      `SSL_OFS_XOVER: v = {r.xover, 15'h0000};
      default: v = 16'h0000;
    endcase
    return v;
  endfunction

  always_comb
  begin
    s_next = s_reg;
    s_next.rdata = 16'h0000;
    if (rd_i)
    begin
      s_next.rdata = ssl_read(addr_i, s_reg);
    end
    // only implemented bits are writable; others read zero
    if (wr_i && addr_i == `SSL_OFS_STRAP)
    begin
      s_next.strap = wdata_i & `SSL_STRAP_WMASK;
    end
    case (s_reg.state)
      SSL_WAIT_CFG:
      begin
        // internal sequence is parked until the done bit is written one
        s_next.int_rst = 1'b1;
        if (s_reg.strap[`SSL_BIT_DONE])
        begin
          s_next.state = SSL_PULSE;
          s_next.cnt = 8'(PULSE_CYC - 1);
          s_next.xover = s_reg.strap[`SSL_BIT_XOVER];
          s_next.negen = s_reg.strap[`SSL_BIT_NEGEN];
          s_next.mode = s_reg.strap[`SSL_BIT_MODE_HI:`SSL_BIT_MODE_LO];
          s_next.bmc = dec_bmc;
          s_next.adv = dec_adv;
        end
      end
      SSL_PULSE:
      begin
        s_next.int_rst = 1'b1;
        if (s_reg.cnt == 8'h00)
        begin
          s_next.state = SSL_RUN;
          s_next.int_rst = 1'b0;
          s_next.done = 1'b1;
        end
        else
        begin
          s_next.cnt = s_reg.cnt - 8'h01;
        end
      end
      SSL_RUN:
      begin
        // later strap writes stay in the register only; nothing is latched again before a reset
        s_next.int_rst = 1'b0;
      end
      default:
      begin
        s_next.state = SSL_WAIT_CFG;
      end
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      s_reg.state <= SSL_WAIT_CFG;
      s_reg.strap <= `SSL_STRAP_RST;
      s_reg.cnt <= 8'h00;
      s_reg.int_rst <= 1'b1;
      s_reg.done <= 1'b0;
      s_reg.xover <= 1'b1;
      s_reg.negen <= 1'b1;
      s_reg.mode <= 2'b11;
      s_reg.bmc <= `SSL_BMC_RST;
      s_reg.adv <= `SSL_ADV_RST;
      s_reg.rdata <= 16'h0000;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  assign rdata_o = s_reg.rdata;
  assign int_rst_o = s_reg.int_rst;
  assign seq_done_o = s_reg.done;
  assign crossover_auto_enable_o = s_reg.xover;
  assign negotiation_enable_o = s_reg.negen;
  assign negotiation_mode_select_o = s_reg.mode;
  assign basic_mode_control_o = s_reg.bmc;
  assign advertise_ability_o = s_reg.adv;
endmodule

/* common/ssl_consts.svh */
// constants of the software strap loader
`ifndef SSL_CONSTS_SVH
`define SSL_CONSTS_SVH
`define SSL_ADDR_W 5
`define SSL_OFS_STRAP 5'h09
`define SSL_OFS_STATUS 5'h0a
`define SSL_OFS_BMC 5'h00
`define SSL_OFS_ADV 5'h04
`define SSL_OFS_XOVER 5'h19
`define SSL_BIT_DONE 15
`define SSL_BIT_XOVER 14
`define SSL_BIT_NEGEN 13
`define SSL_BIT_MODE_HI 12
`define SSL_BIT_MODE_LO 11
`define SSL_STRAP_RST 16'h7800
`define SSL_BMC_RST 16'h1000
`define SSL_ADV_RST 16'h01e1
`define SSL_STRAP_WMASK 16'hf800
`define SSL_BMC_NEGEN 12
`define SSL_BMC_SPEED 13
`define SSL_BMC_DUPLEX 8
`define SSL_ADV_10HD 5
`define SSL_ADV_10FD 6
`define SSL_ADV_100HD 7
`define SSL_ADV_100FD 8
`define SSL_ADV_SEL 16'h0001
`define SSL_XOVER_BIT 15
`define SSL_PULSE_NS 100
`define SSL_CLK_NS 20
`define SSL_PULSE_CYC ((`SSL_PULSE_NS + `SSL_CLK_NS - 1) / `SSL_CLK_NS)
`endif

/* common/ssl_pkg.sv */
// types of the software strap loader
package ssl_pkg;
  typedef enum logic [1:0] {
    SSL_WAIT_CFG,
    SSL_PULSE,
    SSL_RUN
  } ssl_state_t;
endpackage

/* logic/ssl_decode.sv */
// decoder from strap bits to mode control and advertisement words
`include "ssl_consts.svh"
module ssl_decode
  import ssl_pkg::*;
(
  input wire logic negen_i,
  input wire logic [1:0] mode_i,
  output logic [15:0] bmc_o,
  output logic [15:0] adv_o
);
  always_comb
  begin
    bmc_o = 16'h0000;
    adv_o = `SSL_ADV_SEL;
    bmc_o[`SSL_BMC_NEGEN] = negen_i;
    if (!negen_i)
    begin
      // forced: high bit speed, low bit duplex
      bmc_o[`SSL_BMC_SPEED] = mode_i[1];
      bmc_o[`SSL_BMC_DUPLEX] = mode_i[0];
      adv_o[`SSL_ADV_10HD] = 1'b1;
      adv_o[`SSL_ADV_10FD] = 1'b1;
      adv_o[`SSL_ADV_100HD] = 1'b1;
      adv_o[`SSL_ADV_100FD] = 1'b1;
    end
    else
    begin
      case (mode_i)
        2'b00:
        begin
          adv_o[`SSL_ADV_10HD] = 1'b1;
          adv_o[`SSL_ADV_10FD] = 1'b1;
        end
        2'b01:
        begin
          adv_o[`SSL_ADV_100HD] = 1'b1;
          adv_o[`SSL_ADV_100FD] = 1'b1;
        end
        2'b10:
        begin
          adv_o[`SSL_ADV_10HD] = 1'b1;
          adv_o[`SSL_ADV_100HD] = 1'b1;
        end
        default:
        begin
          adv_o[`SSL_ADV_10HD] = 1'b1;
          adv_o[`SSL_ADV_10FD] = 1'b1;
          adv_o[`SSL_ADV_100HD] = 1'b1;
          adv_o[`SSL_ADV_100FD] = 1'b1;
        end
      endcase
    end
  end
endmodule

/* bench/ssl_loader_checker.sv */
// port assertions for the strap loader
module ssl_loader_checker
(
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input wire logic [4:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [15:0] rdata_o,
  input wire logic int_rst_o,
  input wire logic seq_done_o,
  input wire logic crossover_auto_enable_o,
  input wire logic negotiation_enable_o,
  input wire logic [1:0] negotiation_mode_select_o,
  input wire logic [15:0] basic_mode_control_o,
  input wire logic [15:0] advertise_ability_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!nrst_i);
  sequence done_wr;
    wr_i && addr_i == 5'h09 && wdata_i[15] && !seq_done_o;
  endsequence
  idle_rdata_a: assert property (!rd_i |=> rdata_o == 16'h0)
    else $error("rdata not idle");
  reset_hold_a: assert property (!seq_done_o |-> int_rst_o)
    else $error("reset released early");
  done_pulse_a: assert property (done_wr |-> ##[1:8] $rose(seq_done_o))
    else $error("no latch pulse");
  cfg_frozen_a: assert property (seq_done_o |=>
    $stable(basic_mode_control_o) && $stable(negotiation_enable_o))
    else $error("config moved");
  xover_frozen_a: assert property (seq_done_o |=>
    $stable(crossover_auto_enable_o)) else $error("crossover moved");
  latch_only_a: assert property ($changed(negotiation_mode_select_o)
    |-> int_rst_o && !seq_done_o) else $error("latch outside pulse");
  forced_mode_a: assert property (!negotiation_enable_o |->
    basic_mode_control_o[13:12] == {negotiation_mode_select_o[1], 1'b0})
    else $error("forced decode");
  negen_map_a: assert property (
    basic_mode_control_o[12] == negotiation_enable_o) else $error("negen");
  adv_sel_a: assert property (advertise_ability_o[4:0] == 5'h01)
    else $error("selector");
endmodule
bind ssl_loader ssl_loader_checker chk (
  .sys_clk_i(sys_clk_i),
  .nrst_i(nrst_i),
  .addr_i(addr_i),
  .wdata_i(wdata_i),
  .wr_i(wr_i),
  .rd_i(rd_i),
  .rdata_o(rdata_o),
  .int_rst_o(int_rst_o),
  .seq_done_o(seq_done_o),
  .crossover_auto_enable_o(crossover_auto_enable_o),
  .negotiation_enable_o(negotiation_enable_o),
  .negotiation_mode_select_o(negotiation_mode_select_o),
  .basic_mode_control_o(basic_mode_control_o),
  .advertise_ability_o(advertise_ability_o)
);

/* bench/tb.sv */
// self-checking bench for the strap loader
`include "ssl_consts.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk_i = 0, nrst_i = 0, wr_i = 0, rd_i = 0;
  logic [4:0] addr_i = '0;
  logic [15:0] wdata_i = '0, rdata_o, q;
  logic [15:0] basic_mode_control_o, advertise_ability_o;
  logic int_rst_o, seq_done_o, crossover_auto_enable_o;
  logic negotiation_enable_o;
  logic [1:0] negotiation_mode_select_o;
  int mismatches = 0, check_count = 0;
  int wait_n = 0;
  // rows: address, write data, read back
  logic [36:0] rows [5] = '{{5'h09, 16'h47ff, 16'h4000},
    {5'h0a, 16'hffff, 16'h0005}, {5'h03, 16'hffff, 16'h0000},
    {5'h00, 16'hffff, 16'h1000}, {5'h04, 16'h0000, 16'h01e1}};
  always #10 sys_clk_i = ~sys_clk_i;
  ssl_loader dut (
    .sys_clk_i(sys_clk_i),
    .nrst_i(nrst_i),
    .addr_i(addr_i),
    .wdata_i(wdata_i),
    .wr_i(wr_i),
    .rd_i(rd_i),
    .rdata_o(rdata_o),
    .int_rst_o(int_rst_o),
    .seq_done_o(seq_done_o),
    .crossover_auto_enable_o(crossover_auto_enable_o),
    .negotiation_enable_o(negotiation_enable_o),
    .negotiation_mode_select_o(negotiation_mode_select_o),
    .basic_mode_control_o(basic_mode_control_o),
    .advertise_ability_o(advertise_ability_o)
  );
  task automatic chk(input logic [15:0] s, e);
    check_count++;
    if (s !== e)
    begin
      mismatches++;
      $display("[ERR] %0t seen %h exp %h", $time, s, e);
    end
  endtask
  task automatic acc(input logic w, input logic [4:0] a,
    input logic [15:0] d);
    // strobe launched on a rising edge, answer taken mid-cycle
    @(posedge sys_clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= w;
    rd_i <= !w;
    @(posedge sys_clk_i);
    wr_i <= 1'b0;
    rd_i <= 1'b0;
    @(negedge sys_clk_i);
    q = rdata_o;
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial
  begin
    repeat (16) @(posedge sys_clk_i);
    nrst_i <= 1'b1;
    acc(1'b0, 5'h09, 16'h0000);
    chk(q, 16'h7800);
    chk({14'h0000, int_rst_o, seq_done_o}, 16'h0002);
    $display("reset test done");
    foreach (rows[i])
    begin
      acc(1'b1, rows[i][36:32], rows[i][31:16]);
      acc(1'b0, rows[i][36:32], 16'h0000);
      chk(q, rows[i][15:0]);
    end
    // straps written but not yet done must not reach the outputs
    chk({12'h000, crossover_auto_enable_o, negotiation_enable_o,
      negotiation_mode_select_o}, 16'h000f);
    $display("table test done");
    acc(1'b1, 5'h09, 16'h9000);
    wait_n = 0;
    while (wait_n < 20 && seq_done_o !== 1'b1)
    begin
      @(negedge sys_clk_i);
      wait_n++;
    end
    // one edge to see the done bit, then the whole pulse
    chk(wait_n[15:0], 16'(`SSL_PULSE_CYC + 1));
    chk({10'h000, int_rst_o, seq_done_o, crossover_auto_enable_o,
      negotiation_enable_o, negotiation_mode_select_o}, 16'h0012);
    chk(basic_mode_control_o, 16'h2000);
    chk(advertise_ability_o, 16'h01e1);
    acc(1'b0, 5'h19, 16'h0000);
    chk(q, 16'h0000);
    acc(1'b0, 5'h0a, 16'h0000);
    chk(q, 16'h0002);
    acc(1'b1, 5'h09, 16'h6800);
    acc(1'b0, 5'h09, 16'h0000);
    chk(q, 16'h6800);
    chk(basic_mode_control_o, 16'h2000);
    $display("latch test done");
    // a second reset restores defaults and allows one new latch
    @(posedge sys_clk_i);
    nrst_i <= 1'b0;
    repeat (2) @(posedge sys_clk_i);
    nrst_i <= 1'b1;
    acc(1'b0, 5'h09, 16'h0000);
    chk(q, 16'h7800);
    chk({13'h0000, int_rst_o, seq_done_o, crossover_auto_enable_o},
      16'h0005);
    acc(1'b1, 5'h09, 16'ha800);
    repeat (8) @(negedge sys_clk_i);
    chk(basic_mode_control_o, 16'h1000);
    chk(advertise_ability_o, 16'h0181);
    chk({14'h0000, negotiation_mode_select_o}, 16'h0001);
    $display("reset again test done");
    report_and_stop();
  end
  initial
  begin
    #20us;
    mismatches++;
    report_and_stop();
  end
endmodule
